// File: shared/serial_pkg.sv
// constants, types and helpers shared by both ends of the serial controller link
package serial_pkg;
	// pointer and command field of the pointer/command register
	localparam logic [2:0] CMD_NULL = 3'h0;
	localparam logic [2:0] CMD_RST_EXT = 3'h2;
	localparam logic [2:0] CMD_CH_RST = 3'h3;
	localparam logic [2:0] CMD_RX_FIRST = 3'h4;
	localparam logic [2:0] CMD_RST_TXP = 3'h5;
	localparam logic [2:0] CMD_ERR_RST = 3'h6;
	localparam logic [2:0] PTR_CMD = 3'h0;
	localparam logic [2:0] PTR_IMODE = 3'h1;
	localparam logic [2:0] PTR_VEC = 3'h2;
	localparam logic [2:0] PTR_RXC = 3'h3;
	localparam logic [2:0] PTR_FMT = 3'h4;
	localparam logic [2:0] PTR_TXC = 3'h5;
	localparam logic [7:0] REG_RST = 8'h00;
	// interrupt_mode_reg bits
	localparam int IM_EXT_IE = 0, IM_TX_IE = 1, IM_SAV = 2, IM_RXM = 3, IM_WR_EN = 7;
	// receiver_control_reg bits
	localparam int RC_RX_EN = 0, RC_AUTO = 5, RC_LEN = 6;
	// line_format_reg bits
	localparam int LF_PAR_EN = 0, LF_PAR_EVEN = 1, LF_STOP = 2, LF_FACT = 6;
	// transmitter_control_reg bits
	localparam int TC_RTS = 1, TC_TX_EN = 3, TC_BREAK = 4, TC_LEN = 5, TC_DTR = 7;
	// main_status_read and special_status_read bits
	localparam int S0_RX_AV = 0, S0_TX_EMP = 2, S0_DCD = 3, S0_SYNC = 4, S0_CTS = 5, S0_BRK = 7;
	localparam int S1_ALL_SENT = 0, S1_PAR = 4, S1_OVR = 5, S1_FRM = 6;
	// interrupt causes and vector codes
	localparam int CZ_EXT = 0, CZ_TX = 1, CZ_RX = 2, CZ_SPC = 3;
	localparam logic [1:0] VEC_TX = 2'h0, VEC_EXT = 2'h1, VEC_RX = 2'h2, VEC_SPC = 2'h3;
	localparam logic [2:0] VEC_NONE = 3'h3;
	// host controller register map and fields
	localparam logic [7:0] HR_CMD = 8'h00, HR_RES = 8'h04, HR_STAT = 8'h08, HR_MASK = 8'h0c;
	localparam int HC_CTRL = 8, HC_CHB = 9, HC_WR = 10, HC_INTA = 11, HR_BUSY = 8;
	localparam int ST_DONE = 0, ST_DEVINT = 1, ST_REFUSED = 2, ST_W = 3;
	localparam logic [1:0] RESP_OKAY = 2'h0, RESP_SLVERR = 2'h2;
	// frame sequencer states, shared by transmitter and receiver
	typedef enum logic [4:0] {
		F_IDLE = 5'h01, F_START = 5'h02, F_DATA = 5'h04, F_PAR = 5'h08, F_STOP = 5'h10
	} frame_st_t;
	typedef enum logic [1:0] {H_IDLE = 2'h1, H_WAIT = 2'h2} host_st_t;
	// character length code to bit count
	function automatic logic [3:0] len_of(input logic [1:0] c);
		case (c)
			2'h0: return 4'h5;
			2'h2: return 4'h6;
			2'h1: return 4'h7;
			default: return 4'h8;
		endcase
	endfunction
	// clock factor code to bit clock ticks per bit
	function automatic logic [6:0] fact_of(input logic [1:0] c);
		case (c)
			2'h0: return 7'h01;
			2'h1: return 7'h10;
			2'h2: return 7'h20;
			default: return 7'h40;
		endcase
	endfunction
	// stop bit code to ticks: one, one and a half, two bits
	function automatic logic [7:0] stop_of(input logic [1:0] c, input logic [6:0] f);
		case (c)
			2'h2: return {1'b0, f} + {2'h0, f[6:1]};
			2'h3: return {f, 1'b0};
			default: return {1'b0, f};
		endcase
	endfunction
endpackage

// File: shared/serial_bus_if.sv
// parallel bus between the host controller and the serial device
`timescale 1ns/1ps
interface serial_bus_if;
	logic req; // one-cycle request strobe
	logic wr;
	logic chan_b;
	logic ctrl;
	logic inta;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic ack; // one-cycle answer
	logic int_req;
	modport host (output req, wr, chan_b, ctrl, inta, wdata, input rdata, ack, int_req);
	modport dev (input req, wr, chan_b, ctrl, inta, wdata, output rdata, ack, int_req);
endinterface

// File: core/serial_dev.sv
// dual-channel asynchronous serial device with vectored interrupts
// Summary of operation
// - pointer/command register selects register, resets status latch
// - host programs format before interrupt mode, receiver and transmitter control
// - receiver control holds enable, auto, length
// - transmitter control drives rts, dtr, enable, length
// - auto enables gate transmitter by cts, receiver by dcd
// - interrupt mode holds five enable options
// - modem line changes and break raise status interrupt
// - vector register only in second channel
// - no empty interrupt before first byte written
// - acknowledge returns modified vector on data bus
// - status-affects-vector encodes the cause
// - eight vectors, four causes per channel
// - foreign host reads vector during acknowledge
// - all-sent set when shifter idle and transmit buffer empty
// - host reprograms modes then disables at end
// - overrun replaces char, flagged when read
// - read clears available; empty flag tracks buffer
`timescale 1ns/1ps
module serial_dev import serial_pkg::*; (
	// clock and reset
	input logic aclk,
	input logic aresetn,
	// parallel bus toward the host
	serial_bus_if.dev bus,
	// bit clock enables per channel, index 0 is channel a
	input logic [1:0] rx_tick,
	input logic [1:0] tx_tick,
	// serial and modem lines
	input logic [1:0] rxd,
	input logic [1:0] cts_n,
	input logic [1:0] dcd_n,
	input logic [1:0] sync_n,
	output logic [1:0] txd,
	output logic [1:0] rts_n,
	output logic [1:0] dtr_n
);
	logic [7:0] vec_base_r;
	logic [7:0] vec_mod;
	logic [2:0] vcode;
	logic [7:0] rr_ctl [2];
	logic [7:0] rx_dat [2];
	logic [3:0] cause [2];
	logic [1:0] sav;
	logic [1:0] wr2_we;
	logic ack_r;
	logic int_r;
	logic [7:0] rdata_r;

	genvar gi;
	for (gi = 0; gi < 2; gi++) begin : ch
		localparam logic CHB = (gi == 1);
		logic [7:0] wr1_r, wr3_r, wr4_r, wr5_r;
		logic [2:0] ptr_r, cmd;
		logic sel, cwr, crd, dwr, drd, crst;
		logic [6:0] fact;
		logic [7:0] stop;
		logic tx_run, rx_run, tload, rdone;
		logic [7:0] tbuf_r, tsh_r, ttk_r, tlim;
		logic tfull_r, tpend_r, tpar_r, txd_r, rts_n_r, dtr_n_r;
		logic [3:0] tbit_r, rbit_r;
		frame_st_t tst_r, rst_r;
		logic [7:0] rsh_r, rtk_r, rbuf_r, rr0, rr1;
		logic rpar_r, rperr_r, ravail_r, brk_r, first_r, epend_r;
		logic [2:0] rerr_r, sticky_r; // parity, overrun, framing
		logic [3:0] lat_r, live; // break, cts, sync, dcd
		logic [1:0] rxm;

		// access decode for this channel
		assign sel = bus.req & ~bus.inta & (bus.chan_b == CHB);
		assign cwr = sel & bus.ctrl & bus.wr;
		assign crd = sel & bus.ctrl & ~bus.wr;
		assign dwr = sel & ~bus.ctrl & bus.wr;
		assign drd = sel & ~bus.ctrl & ~bus.wr;
		assign cmd = (cwr && ptr_r == PTR_CMD) ? bus.wdata[5:3] : CMD_NULL;
		assign crst = (cmd == CMD_CH_RST);
		assign wr2_we[gi] = CHB & cwr & (ptr_r == PTR_VEC);
		assign fact = fact_of(wr4_r[LF_FACT +: 2]);
		assign stop = stop_of(wr4_r[LF_STOP +: 2], fact);
		assign rxm = wr1_r[IM_RXM +: 2];
		assign tx_run = wr5_r[TC_TX_EN] & (~wr3_r[RC_AUTO] | ~cts_n[gi]);
		assign rx_run = wr3_r[RC_RX_EN] & (~wr3_r[RC_AUTO] | ~dcd_n[gi]);

		// pointer and write registers; pointer returns to zero after each control read and each write to a pointed register
		always_ff @(posedge aclk) begin
			if (!aresetn || crst) begin
				ptr_r <= PTR_CMD;
				wr1_r <= REG_RST;
				wr3_r <= REG_RST;
				wr4_r <= REG_RST;
				wr5_r <= REG_RST;
			end else if (cwr) begin
				if (ptr_r == PTR_CMD) begin
					ptr_r <= bus.wdata[2:0];
				end else begin
					case (ptr_r)
						PTR_IMODE: wr1_r <= bus.wdata;
						PTR_RXC: wr3_r <= bus.wdata;
						PTR_FMT: wr4_r <= bus.wdata;
						PTR_TXC: wr5_r <= bus.wdata;
						default: ;
					endcase
					ptr_r <= PTR_CMD;
				end
			end else if (crd) begin
				ptr_r <= PTR_CMD;
			end
		end

		// modem control outputs
		always_ff @(posedge aclk) begin
			if (!aresetn || crst) begin
				rts_n_r <= 1'b1;
				dtr_n_r <= 1'b1;
			end else begin
				rts_n_r <= ~wr5_r[TC_RTS];
				dtr_n_r <= ~wr5_r[TC_DTR];
			end
		end
		assign rts_n[gi] = rts_n_r;
		assign dtr_n[gi] = dtr_n_r;
		assign txd[gi] = txd_r;

		// transmit buffer and its empty interrupt
		assign tload = (tst_r == F_IDLE) & tfull_r & tx_run;
		always_ff @(posedge aclk) begin
			if (!aresetn || crst) begin
				tfull_r <= 1'b0;
				tbuf_r <= REG_RST;
			end else if (dwr) begin
				tbuf_r <= bus.wdata;
				tfull_r <= 1'b1;
			end else if (tload) begin
				tfull_r <= 1'b0;
			end
		end
		always_ff @(posedge aclk) begin
			if (!aresetn || crst) begin
				tpend_r <= 1'b0;
			end else if (tload) begin
				tpend_r <= 1'b1; // only after a byte was written
			end else if (dwr || cmd == CMD_RST_TXP) begin
				tpend_r <= 1'b0;
			end
		end

		// transmit frame sequencer; break only spaces the line between characters
		assign tlim = (tst_r == F_STOP) ? stop : {1'b0, fact};
		always_ff @(posedge aclk) begin
			if (!aresetn || crst) begin
				tst_r <= F_IDLE;
				txd_r <= 1'b1;
				ttk_r <= 8'h00;
				tbit_r <= 4'h0;
				tsh_r <= 8'h00;
				tpar_r <= 1'b0;
			end else if (tst_r == F_IDLE) begin
				txd_r <= ~wr5_r[TC_BREAK];
				if (tload) begin
					tsh_r <= tbuf_r;
					tpar_r <= ~wr4_r[LF_PAR_EVEN];
					tbit_r <= 4'h0;
					ttk_r <= 8'h00;
					txd_r <= 1'b0;
					tst_r <= F_START;
				end
			end else if (tx_tick[gi]) begin
				if (ttk_r != tlim - 8'h01) begin
					ttk_r <= ttk_r + 8'h01;
				end else begin
					ttk_r <= 8'h00;
					case (tst_r)
						F_START: begin
							txd_r <= tsh_r[0];
							tst_r <= F_DATA;
						end
						F_DATA: begin
							tpar_r <= tpar_r ^ tsh_r[0];
							tsh_r <= {1'b0, tsh_r[7:1]};
							tbit_r <= tbit_r + 4'h1;
							if (tbit_r == len_of(wr5_r[TC_LEN +: 2]) - 4'h1) begin
								txd_r <= wr4_r[LF_PAR_EN] ? (tpar_r ^ tsh_r[0]) : 1'b1;
								tst_r <= wr4_r[LF_PAR_EN] ? F_PAR : F_STOP;
							end else begin
								txd_r <= tsh_r[1];
							end
						end
						F_PAR: begin
							txd_r <= 1'b1;
							tst_r <= F_STOP;
						end
						default: tst_r <= F_IDLE;
					endcase
				end
			end
		end

		// receive frame sequencer, sampling mid-bit
		assign rdone = (rst_r == F_STOP) & rx_tick[gi] & (rtk_r == {1'b0, fact} - 8'h01);
		always_ff @(posedge aclk) begin
			if (!aresetn || crst) begin
				rst_r <= F_IDLE;
				rtk_r <= 8'h00;
				rbit_r <= 4'h0;
				rsh_r <= 8'h00;
				rpar_r <= 1'b0;
				rperr_r <= 1'b0;
				brk_r <= 1'b0;
			end else begin
				case (rst_r)
					F_IDLE: begin
						if (brk_r && rxd[gi]) begin
							brk_r <= 1'b0; // break sequence ended
						end else if (!brk_r && rx_run && !rxd[gi]) begin
							rtk_r <= 8'h00;
							rst_r <= F_START;
						end
					end
					F_START: if (rx_tick[gi]) begin
						if (rtk_r != {2'h0, fact[6:1]}) begin
							rtk_r <= rtk_r + 8'h01;
						end else begin
							rtk_r <= 8'h00;
							rbit_r <= 4'h0;
							rperr_r <= 1'b0;
							rpar_r <= ~wr4_r[LF_PAR_EVEN];
							rst_r <= rxd[gi] ? F_IDLE : F_DATA;
						end
					end
					default: if (rx_tick[gi]) begin
						if (rtk_r != {1'b0, fact} - 8'h01) begin
							rtk_r <= rtk_r + 8'h01;
						end else begin
							rtk_r <= 8'h00;
							if (rst_r == F_DATA) begin
								rsh_r <= {rxd[gi], rsh_r[7:1]};
								rpar_r <= rpar_r ^ rxd[gi];
								rbit_r <= rbit_r + 4'h1;
								if (rbit_r == len_of(wr3_r[RC_LEN +: 2]) - 4'h1) begin
									rst_r <= wr4_r[LF_PAR_EN] ? F_PAR : F_STOP;
								end
							end else if (rst_r == F_PAR) begin
								rperr_r <= rpar_r ^ rxd[gi];
								rst_r <= F_STOP;
							end else begin
								brk_r <= ~rxd[gi] & (rsh_r == 8'h00);
								rst_r <= F_IDLE;
							end
						end
					end
				endcase
			end
		end

		// receive buffer: newest character overwrites, errors travel with it
		always_ff @(posedge aclk) begin
			if (!aresetn || crst) begin
				ravail_r <= 1'b0;
				rbuf_r <= REG_RST;
				rerr_r <= 3'h0;
			end else if (rdone) begin
				rbuf_r <= rsh_r >> (4'h8 - len_of(wr3_r[RC_LEN +: 2]));
				rerr_r <= {~rxd[gi], ravail_r & ~drd, rperr_r};
				ravail_r <= 1'b1;
			end else if (drd) begin
				ravail_r <= 1'b0;
			end
		end
		assign rx_dat[gi] = rbuf_r;

		// error flags become visible when their character is read
		always_ff @(posedge aclk) begin
			if (!aresetn || crst) begin
				sticky_r <= 3'h0;
				first_r <= 1'b0;
			end else begin
				if (drd) begin
					sticky_r <= (cmd == CMD_ERR_RST ? 3'h0 : sticky_r) | rerr_r;
				end else if (cmd == CMD_ERR_RST) begin
					sticky_r <= 3'h0;
				end
				if (cmd == CMD_RX_FIRST) begin
					first_r <= 1'b1;
				end else if (drd) begin
					first_r <= 1'b0;
				end
			end
		end

		// external/status latch: tracks lines until a change, then freezes if the external interrupt is enabled
		assign live = {brk_r, ~cts_n[gi], ~sync_n[gi], ~dcd_n[gi]};
		always_ff @(posedge aclk) begin
			if (!aresetn || crst) begin
				lat_r <= 4'h0;
				epend_r <= 1'b0;
			end else if (cmd == CMD_RST_EXT) begin
				lat_r <= live;
				epend_r <= 1'b0;
			end else if (!epend_r && live != lat_r) begin
				lat_r <= live;
				epend_r <= wr1_r[IM_EXT_IE];
			end
		end

		// status read registers and interrupt causes
		always_comb begin
			rr0 = 8'h00;
			rr0[S0_RX_AV] = ravail_r;
			rr0[S0_TX_EMP] = ~tfull_r;
			rr0[S0_DCD] = lat_r[0];
			rr0[S0_SYNC] = lat_r[1];
			rr0[S0_CTS] = lat_r[2];
			rr0[S0_BRK] = lat_r[3];
			rr1 = 8'h00;
			rr1[S1_ALL_SENT] = (tst_r == F_IDLE) & ~tfull_r;
			rr1[S1_PAR] = sticky_r[0];
			rr1[S1_OVR] = sticky_r[1];
			rr1[S1_FRM] = sticky_r[2];
			case (ptr_r)
				PTR_CMD: rr_ctl[gi] = rr0;
				PTR_IMODE: rr_ctl[gi] = rr1;
				PTR_VEC: rr_ctl[gi] = CHB ? vec_mod : 8'h00;
				default: rr_ctl[gi] = 8'h00;
			endcase
			cause[gi][CZ_EXT] = wr1_r[IM_EXT_IE] & epend_r;
			cause[gi][CZ_TX] = wr1_r[IM_TX_IE] & tpend_r;
			cause[gi][CZ_RX] = ravail_r & ~|rerr_r & (rxm[1] | (rxm[0] & first_r));
			cause[gi][CZ_SPC] = ravail_r & |rerr_r & (rxm != 2'h0);
		end
		assign sav[gi] = CHB & wr1_r[IM_SAV];
	end

	// single vector register, written through the second channel only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			vec_base_r <= REG_RST;
		end else if (wr2_we[1]) begin
			vec_base_r <= bus.wdata;
		end
	end

	// highest cause wins: channel a first, then special, rx, tx, ext
	always_comb begin
		vcode = VEC_NONE;
		for (int i = 1; i >= 0; i--) begin
			if (cause[i][CZ_EXT]) vcode = {i == 0, VEC_EXT};
			if (cause[i][CZ_TX]) vcode = {i == 0, VEC_TX};
			if (cause[i][CZ_RX]) vcode = {i == 0, VEC_RX};
			if (cause[i][CZ_SPC]) vcode = {i == 0, VEC_SPC};
		end
		vec_mod = sav[1] ? {vec_base_r[7:4], vcode, vec_base_r[0]} : vec_base_r;
	end

	// bus answer one cycle after each request, and interrupt request
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ack_r <= 1'b0;
			rdata_r <= 8'h00;
			int_r <= 1'b0;
		end else begin
			ack_r <= bus.req;
			int_r <= |{cause[0], cause[1]};
			if (bus.req && bus.inta) begin
				rdata_r <= vec_mod;
			end else if (bus.req && !bus.wr) begin
				rdata_r <= bus.ctrl ? rr_ctl[bus.chan_b] : rx_dat[bus.chan_b];
			end
		end
	end
	assign bus.ack = ack_r;
	assign bus.rdata = rdata_r;
	assign bus.int_req = int_r;
endmodule // serial_dev

// File: core/serial_host.sv
// host controller: AXI4-Lite registers driving the device's parallel bus
`timescale 1ns/1ps
module serial_host import serial_pkg::*; (
	// clock and reset
	input logic aclk,
	input logic aresetn,
	// AXI4-Lite slave
	input logic [7:0] awaddr,
	input logic awvalid,
	output logic awready,
	input logic [31:0] wdata,
	input logic [3:0] wstrb,
	input logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input logic bready,
	input logic [7:0] araddr,
	input logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input logic rready,
	// interrupt
	output logic irq,
	// parallel bus toward the device
	serial_bus_if.host bus
);
	logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r, irq_r;
	logic [1:0] bresp_r, rresp_r;
	logic [31:0] rdata_r, wd_r, bm;
	logic [7:0] wa_r, res_r;
	logic [3:0] ws_r;
	logic aw_h, w_h, fire, go, refuse, int_d_r;
	logic [ST_W-1:0] stat_r, mask_r, set_ev;
	host_st_t hst_r;
	logic req_r, wr_r, chb_r, ctrl_r, inta_r;
	logic [7:0] bwd_r;
	logic [2:0] ptr_st_r [2];
	logic [1:0] fmt_ok_r;

	// write address and data taken in either order, answered after both
	assign fire = aw_h & w_h & ~bvalid_r;
	assign bm = {{8{ws_r[3]}}, {8{ws_r[2]}}, {8{ws_r[1]}}, {8{ws_r[0]}}};
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_h <= 1'b0;
			w_h <= 1'b0;
			awready_r <= 1'b1;
			wready_r <= 1'b1;
			wa_r <= 8'h00;
			wd_r <= 32'h0;
			ws_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
		end else begin
			if (awvalid && awready_r) begin
				aw_h <= 1'b1;
				wa_r <= awaddr;
				awready_r <= 1'b0;
			end else if (fire) begin
				aw_h <= 1'b0;
				awready_r <= 1'b1;
			end
			if (wvalid && wready_r) begin
				w_h <= 1'b1;
				wd_r <= wdata;
				ws_r <= wstrb;
				wready_r <= 1'b0;
			end else if (fire) begin
				w_h <= 1'b0;
				wready_r <= 1'b1;
			end
			if (fire) begin
				bvalid_r <= 1'b1;
				bresp_r <= (wa_r > HR_MASK || wa_r[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY;
			end else if (bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	// read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b1;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0;
			rresp_r <= RESP_OKAY;
		end else if (arvalid && arready_r) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b1;
			rresp_r <= RESP_OKAY;
			case (araddr)
				HR_RES: rdata_r <= {23'h0, hst_r != H_IDLE, res_r};
				HR_STAT: rdata_r <= {29'h0, stat_r};
				HR_MASK: rdata_r <= {29'h0, mask_r};
				HR_CMD: rdata_r <= {20'h0, inta_r, wr_r, chb_r, ctrl_r, bwd_r};
				default: begin
					rdata_r <= 32'h0;
					rresp_r <= RESP_SLVERR;
				end
			endcase
		end else if (rvalid_r && rready) begin
			rvalid_r <= 1'b0;
			arready_r <= 1'b1;
		end
	end

	// a command write starts one device transfer; format must precede interrupt mode, receiver and transmitter control writes
	assign go = fire & (wa_r == HR_CMD) & ws_r[0] & ws_r[1];
	always_comb begin
		refuse = hst_r != H_IDLE;
		if (wd_r[HC_CTRL] && wd_r[HC_WR] && !wd_r[HC_INTA] && !fmt_ok_r[wd_r[HC_CHB]]) begin
			case (ptr_st_r[wd_r[HC_CHB]])
				PTR_IMODE, PTR_RXC, PTR_TXC: refuse = 1'b1;
				default: ;
			endcase
		end
	end

	// device transfer sequencer; inta reads the modified vector
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hst_r <= H_IDLE;
			req_r <= 1'b0;
			wr_r <= 1'b0;
			chb_r <= 1'b0;
			ctrl_r <= 1'b0;
			inta_r <= 1'b0;
			bwd_r <= 8'h00;
			res_r <= 8'h00;
		end else begin
			req_r <= 1'b0;
			case (hst_r)
				H_IDLE: if (go && !refuse) begin
					req_r <= 1'b1;
					bwd_r <= wd_r[7:0]; // data byte also starts transmission
					ctrl_r <= wd_r[HC_CTRL];
					chb_r <= wd_r[HC_CHB];
					wr_r <= wd_r[HC_WR] & ~wd_r[HC_INTA];
					inta_r <= wd_r[HC_INTA];
					hst_r <= H_WAIT;
				end
				H_WAIT: if (bus.ack) begin
					res_r <= bus.rdata;
					hst_r <= H_IDLE;
				end
				default: hst_r <= H_IDLE;
			endcase
		end
	end

	// mirror of the device pointer, to know when format has been written
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ptr_st_r[0] <= PTR_CMD;
			ptr_st_r[1] <= PTR_CMD;
			fmt_ok_r <= 2'h0;
		end else if (go && !refuse && wd_r[HC_CTRL] && !wd_r[HC_INTA]) begin
			if (!wd_r[HC_WR]) begin
				ptr_st_r[wd_r[HC_CHB]] <= PTR_CMD;
			end else if (ptr_st_r[wd_r[HC_CHB]] == PTR_CMD) begin
				ptr_st_r[wd_r[HC_CHB]] <= wd_r[2:0];
				if (wd_r[5:3] == CMD_CH_RST) begin
					fmt_ok_r[wd_r[HC_CHB]] <= 1'b0;
					ptr_st_r[wd_r[HC_CHB]] <= PTR_CMD;
				end
			end else begin
				if (ptr_st_r[wd_r[HC_CHB]] == PTR_FMT) fmt_ok_r[wd_r[HC_CHB]] <= 1'b1;
				ptr_st_r[wd_r[HC_CHB]] <= PTR_CMD; // mode and disable writes stay open
			end
		end
	end

	// sticky status, write one to clear, set wins; mask gates irq
	always_comb begin
		set_ev = '0;
		set_ev[ST_DONE] = (hst_r == H_WAIT) & bus.ack;
		set_ev[ST_DEVINT] = bus.int_req & ~int_d_r;
		set_ev[ST_REFUSED] = go & refuse;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stat_r <= '0;
			mask_r <= '0;
			int_d_r <= 1'b0;
			irq_r <= 1'b0;
		end else begin
			int_d_r <= bus.int_req;
			if (fire && wa_r == HR_STAT) begin
				stat_r <= (stat_r & ~(wd_r[ST_W-1:0] & bm[ST_W-1:0])) | set_ev;
			end else begin
				stat_r <= stat_r | set_ev;
			end
			if (fire && wa_r == HR_MASK && ws_r[0]) mask_r <= wd_r[ST_W-1:0];
			irq_r <= |(stat_r & mask_r);
		end
	end

	assign awready = awready_r;
	assign wready = wready_r;
	assign bvalid = bvalid_r;
	assign bresp = bresp_r;
	assign arready = arready_r;
	assign rvalid = rvalid_r;
	assign rdata = rdata_r;
	assign rresp = rresp_r;
	assign irq = irq_r;
	assign bus.req = req_r;
	assign bus.wr = wr_r;
	assign bus.chan_b = chb_r;
	assign bus.ctrl = ctrl_r;
	assign bus.inta = inta_r;
	assign bus.wdata = bwd_r;
endmodule // serial_host

// File: testbench/serial_link_monitor.sv
// bus checks between host controller and serial device
`timescale 1ns/1ps
module serial_link_monitor (
	// clock and reset
	input logic aclk,
	input logic aresetn,
	// bus signals
	input logic req,
	input logic wr,
	input logic chan_b,
	input logic ctrl,
	input logic inta,
	input logic [7:0] wdata,
	input logic [7:0] rdata,
	input logic ack,
	input logic int_req
);
	logic [2:0] ptr_r [2];
	logic wr_q_r;
	logic any_wr_r;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// shadow of each channel's pointer
	always_ff @(posedge aclk) begin
		if (!aresetn)
			ptr_r <= '{default: 3'h0};
		else if (req && ctrl && !inta)
			ptr_r[chan_b] <= (wr && ptr_r[chan_b] == 3'h0) ? wdata[2:0] : 3'h0;
	end
	// last request a write, any write since reset
	always_ff @(posedge aclk) begin
		wr_q_r <= aresetn && req && wr;
		any_wr_r <= aresetn && (any_wr_r || (req && wr));
	end
	sequence s_vec_a; req && ctrl && !wr && !inta && !chan_b && ptr_r[0] == 3'h2; endsequence
	sequence s_answer; ack ##1 !ack; endsequence
	property p_ack_follows; req |=> s_answer; endproperty
	property p_ack_cause; ack |-> $past(req); endproperty
	property p_req_pulse; req |=> !req; endproperty
	property p_inta_read; req && inta |-> !wr; endproperty
	property p_rdata_hold; (!ack || wr_q_r) |-> $stable(rdata); endproperty
	property p_vec_a_zero; s_vec_a |=> ack && rdata == 8'h00; endproperty
	property p_quiet_boot; !any_wr_r |-> !int_req; endproperty
	property p_ack_pulse; ack |=> !ack; endproperty
	a_ack_follows: assert property (p_ack_follows) else $error("no answer after request");
	a_ack_cause: assert property (p_ack_cause) else $error("answer without request");
	a_req_pulse: assert property (p_req_pulse) else $error("request longer than a cycle");
	a_inta_read: assert property (p_inta_read) else $error("acknowledge marked as write");
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
	a_vec_a_zero: assert property (p_vec_a_zero) else $error("channel a vector not zero");
	a_quiet_boot: assert property (p_quiet_boot) else $error("interrupt before any write");
	a_ack_pulse: assert property (p_ack_pulse) else $error("answer longer than a cycle");
endmodule // serial_link_monitor

// File: testbench/async_serial_channel_interrupt_flow_bench.sv
// host controller and serial device joined, driven over AXI4-Lite
`timescale 1ns/1ps
module async_serial_channel_interrupt_flow_bench import serial_pkg::*;;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid, irq;
	logic [7:0] awaddr, araddr, v;
	logic [31:0] wdata, rdata, rw;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rx_tick, tx_tick, rxd, cts_n, dcd_n, sync_n, txd, rts_n, dtr_n, rs;
	int num_errors, n_compared;
	serial_bus_if link();
	serial_host i_serial_host (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .irq(irq), .bus(link));
	serial_dev i_serial_dev (.aclk(aclk), .aresetn(aresetn), .bus(link), .rx_tick(rx_tick), .tx_tick(tx_tick),
		.rxd(rxd), .cts_n(cts_n), .dcd_n(dcd_n), .sync_n(sync_n), .txd(txd), .rts_n(rts_n), .dtr_n(dtr_n));
	serial_link_monitor mon (.aclk(aclk), .aresetn(aresetn), .req(link.req), .wr(link.wr), .chan_b(link.chan_b),
		.ctrl(link.ctrl), .inta(link.inta), .wdata(link.wdata), .rdata(link.rdata), .ack(link.ack),
		.int_req(link.int_req));
	// each channel loops back on itself
	assign rxd = txd;
	// compare and count
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one AXI write, response kept in rs
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		logic ha, hw, hb;
		hb = 1'b0;
		@(posedge aclk);
		{awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
		while (!hb) begin
			@(negedge aclk);
			ha = awvalid & awready;
			hw = wvalid & wready;
			hb = bvalid;
			rs = bresp;
			@(posedge aclk);
			if (ha) awvalid <= 1'b0;
			if (hw) wvalid <= 1'b0;
		end
		bready <= 1'b0;
	endtask
	// one AXI read
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
		logic ha, hr;
		hr = 1'b0;
		@(posedge aclk);
		{araddr, arvalid, rready} <= {a, 2'b11};
		while (!hr) begin
			@(negedge aclk);
			ha = arvalid & arready;
			hr = rvalid;
			d = rdata;
			rs = rresp;
			@(posedge aclk);
			if (ha) arvalid <= 1'b0;
		end
		rready <= 1'b0;
	endtask
	// one device transfer: {inta, wr, chan_b, ctrl, byte}
	task automatic dev(input logic [11:0] c, output logic [7:0] r);
		logic [31:0] s;
		s = 32'h0;
		axi_wr(HR_CMD, {20'h0, c});
		while (!s[ST_DONE]) axi_rd(HR_STAT, s);
		axi_wr(HR_STAT, 32'h1);
		axi_rd(HR_RES, s);
		r = s[7:0];
	endtask
	// pointer then register write
	task automatic wreg(input logic ch, input logic [2:0] p, input logic [7:0] d);
		if (p != PTR_CMD) dev({2'b01, ch, 1'b1, 5'h00, p}, v);
		dev({2'b01, ch, 1'b1, d}, v);
	endtask
	task automatic rreg(input logic ch, input logic [2:0] p);
		if (p != PTR_CMD) dev({2'b01, ch, 1'b1, 5'h00, p}, v);
		dev({2'b00, ch, 1'b1, 8'h00}, v);
	endtask
	// send one byte on channel a, wait for it back
	task automatic loop(input logic [7:0] b);
		dev({4'h4, b}, v);
		rx_expect(b);
	endtask
	// wait for a character on channel a and compare it
	task automatic rx_expect(input logic [7:0] b);
		do rreg(1'b0, PTR_CMD); while (!v[S0_RX_AV]);
		dev({4'h0, 8'h00}, v);
		chk("rx_byte", v, b);
	endtask
	task automatic t_init();
		axi_wr(8'h10, 32'h0);
		chk("bresp", rs, RESP_SLVERR);
		axi_rd(8'h14, rw);
		chk("rresp", rs, RESP_SLVERR);
		chk("rdata_unmapped", rw, 32'h0);
		wreg(1'b0, PTR_CMD, 8'h18);
		wreg(1'b0, PTR_FMT, 8'h44);
		wreg(1'b1, PTR_FMT, 8'h44);
		wreg(1'b0, PTR_RXC, 8'hc1);
		wreg(1'b0, PTR_TXC, 8'hea);
		chk("rts_n", rts_n[0], 1'b0);
		chk("dtr_n", dtr_n[0], 1'b0);
		loop(8'ha5);
		rreg(1'b0, PTR_CMD);
		chk("rx_av", v[S0_RX_AV], 1'b0);
		chk("tx_emp", v[S0_TX_EMP], 1'b1);
		rreg(1'b0, PTR_IMODE);
		chk("all_sent", v[S1_ALL_SENT], 1'b1);
		$display("end init and loop");
	endtask
	// transmitter held by cts under auto enables
	task automatic t_auto();
		cts_n <= 2'b01;
		wreg(1'b0, PTR_RXC, 8'he1);
		dev({4'h4, 8'h00}, v);
		repeat (200) @(posedge aclk);
		rreg(1'b0, PTR_CMD);
		chk("held_rx_av", v[S0_RX_AV], 1'b0);
		chk("held_tx_emp", v[S0_TX_EMP], 1'b0);
		cts_n <= 2'b00;
		rx_expect(8'h00);
		$display("end auto");
	endtask
	// external status interrupt and vector
	task automatic t_vec();
		wreg(1'b1, PTR_VEC, 8'h40);
		wreg(1'b1, PTR_IMODE, 8'h04);
		wreg(1'b0, PTR_CMD, 8'h10);
		wreg(1'b0, PTR_IMODE, 8'h01);
		axi_wr(HR_MASK, 32'h2);
		cts_n <= 2'b01;
		repeat (6) @(posedge aclk);
		chk("int_req", link.int_req, 1'b1);
		chk("irq", irq, 1'b1);
		dev({4'h8, 8'h00}, v);
		chk("vector", v, {4'h4, 1'b1, VEC_EXT, 1'b0});
		rreg(1'b0, PTR_VEC);
		chk("vec_a", v, 8'h00);
		wreg(1'b0, PTR_CMD, 8'h10);
		repeat (4) @(posedge aclk);
		chk("int_clr", link.int_req, 1'b0);
		axi_wr(HR_STAT, 32'h2);
		repeat (2) @(posedge aclk);
		chk("irq_clr", irq, 1'b0);
		wreg(1'b0, PTR_IMODE, 8'h00);
		wreg(1'b0, PTR_TXC, 8'h82);
		wreg(1'b0, PTR_CMD, 8'h18);
		chk("rts_idle", rts_n[0], 1'b1);
		chk("txd_idle", txd[0], 1'b1);
		$display("end vector and reset");
	endtask
	// verdict
	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// clock
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	// hang guard
	initial begin
		repeat (30000) @(posedge aclk);
		num_errors++;
		$display("[ERR] watchdog expected done seen hang");
		summarize();
	end
	// main sequence
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
		{wstrb, rx_tick, tx_tick, cts_n, dcd_n, sync_n} = {4'hf, 2'b11, 2'b11, 2'b00, 2'b00, 2'b11};
		{num_errors, n_compared} = '0;
		aresetn = 1'b0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		t_init();
		t_auto();
		t_vec();
		summarize();
	end
endmodule // async_serial_channel_interrupt_flow_bench
